// file: pkg/dlp_pkg.sv
package dlp_pkg;
  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [31:0] DYN_EN_OFS     = 32'h0004_5504;
  localparam logic [31:0] AUX_CTL_OFS    = 32'h0004_5520;
  localparam logic [31:0] PROG_STORE_OFS = 32'h0009_0000;
  localparam logic [31:0] AUX_CTL_VAL    = 32'h0000_0002;
  localparam int          OFF_ALLOW_BIT  = 3;
  localparam logic [31:0] RST_WDATA      = 32'h0000_0000;

  // ****************************************
  // Enable field settings
  // ****************************************
  localparam logic [1:0] LVL_DISABLE = 2'h0;
  localparam logic [1:0] LVL_SHALLOW = 2'h1;
  localparam logic [1:0] LVL_DEEP    = 2'h2;

  // ****************************************
  // Package and image header checks
  // ****************************************
  localparam logic [31:0] MAP_NO_IMAGE   = 32'hffff_ffff;
  localparam logic [31:0] MODULE_KIND    = 32'h0000_0009;
  localparam logic [31:0] OUTER_HDR_VER  = 32'h0001_0000;
  localparam logic [31:0] IMG_MARKER     = 32'h4040_3e3e;
  localparam logic [4:0]  MAP_MAX_ENTRY  = 5'h14;
  localparam logic [3:0]  INIT_MAX_PAIRS = 4'h8;
  localparam logic [31:0] INIT_ADDR_LO   = 32'h0008_0000;
  localparam logic [31:0] INIT_ADDR_HI   = 32'h0008_ffff;

  // ****************************************
  // Commands and states
  // ****************************************
  typedef enum logic [2:0] {
    CMD_ALLOW_SHALLOW = 3'h0,
    CMD_ALLOW_DEEP    = 3'h1,
    CMD_DISALLOW      = 3'h2,
    CMD_ALLOW_OFF     = 3'h3,
    CMD_DISALLOW_OFF  = 3'h4
  } dlp_cmd_t;

  typedef enum {
    ST_IDLE,
    ST_PAY,
    ST_INI_RD,
    ST_INI_CHK,
    ST_ENW,
    ST_OFFW,
    ST_WAIT,
    ST_REL,
    ST_FIN
  } dlp_state_t;
endpackage : dlp_pkg

// file: logic/dlp_init_tbl.sv
module dlp_init_tbl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        we,
  input  wire logic [2:0]  widx,
  input  wire logic [63:0] wdata,
  input  wire logic [2:0]  ridx,
  output logic      [63:0] rdata_r
);
  // ****************************************
  // Address/data pairs of the image header
  // ****************************************
  logic [63:0] mem [0:7];

  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[widx] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= 64'h0;
    end
    else
    begin
      rdata_r <= mem[ridx];
    end
  end
endmodule : dlp_init_tbl

// file: logic/dlp_host_ctrl.sv
// What the document requires
// [R1] Device enters shallow state only if allowed, upper wells off, pipes idle.
// [R2] Device gates first well and display clock PLL on shallow entry.
// [R3] Device also gates well zero on deep entry after saving it.
// [R4] Deep state needs shallow conditions, software allowance and power agent grant.
// [R5] Deep allowance refused while backlight comes from utility pin.
// [R6] Device clears restore program storage on every reset and suspend.
// [R7] Lookup tables are lost in both states; software reloads them.
// [R8] Other combo PHY ports need reinit after deep state; port A survives.
// [R9] Gamma programming only while both states are disallowed.
// [R10] Allowing loads payload into program storage, then header register writes.
// [R11] Allowing sets bit 1 of the auxiliary control register.
// [R12] Enable field: disable, up to shallow, up to deep.
// [R13] Switching between shallow and deep passes disable and reloads program.
// [R14] Mode sets and port A aux traffic happen only while disallowed.
// [R15] Device keeps serial display IO low-power state through both states.
// [R16] Map offset of all ones means no image for the stepping.
// [R17] Map holds at most twenty valid entries.
// [R18] Outer header has module kind 0x09 and version 0x10000.
// [R19] Image starts with marker and carries at most eight pairs.
// [R20] Header writes lie in 0x80000..0x8FFFF, issued in order.
// [R21] Off allowance: disallow shallow first, then set off-allow bit.
// [R22] Device enters and leaves off state itself, saving config registers.
// [R23] Leaving off allowance clears the off-allow bit.
// [R24] Device finishes restore before acknowledging a pending register access.
module dlp_host_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        backlight_util_pin,
  input  wire logic [31:0] img_offset,
  input  wire logic [31:0] module_kind_field,
  input  wire logic [31:0] outer_hdr_ver,
  input  wire logic [31:0] img_marker,
  input  wire logic [4:0]  map_entry_count,
  input  wire logic [15:0] program_size_field,
  input  wire logic [3:0]  init_write_count,
  input  wire logic        tbl_we,
  input  wire logic [2:0]  tbl_idx,
  input  wire logic [31:0] tbl_addr,
  input  wire logic [31:0] tbl_data,
  input  wire logic        pl_valid,
  input  wire logic [31:0] pl_data,
  input  wire logic        phy_reinit_done,
  input  wire logic        dev_ack,
  output logic             cmd_ready,
  output logic             cmd_err,
  output logic [1:0]       lvl_state,
  output logic             off_allowed,
  output logic             pl_ready,
  output logic             phy_reinit_req,
  output logic             dev_req,
  output logic [31:0]      dev_addr,
  output logic [31:0]      dev_wdata
);
  // ****************************************
  // State and registers
  // ****************************************
  dlp_pkg::dlp_state_t state_r, state_nxt, ret_r, ret_nxt;
  logic [1:0]  level_r, level_nxt, target_r, target_nxt;
  logic        off_r, off_nxt, err_r, err_nxt, rdy_r, rdy_nxt;
  logic        plr_r, plr_nxt, phy_r, phy_nxt, req_r, req_nxt;
  logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic        ack_m_r, ack_s_r;
  logic [63:0] pair;

  dlp_init_tbl u_tbl (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (tbl_we),
    .widx    (tbl_idx),
    .wdata   ({tbl_addr, tbl_data}),
    .ridx    (idx_r[2:0]),
    .rdata_r (pair)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire logic       is_allow  = (cmd_op == dlp_pkg::CMD_ALLOW_SHALLOW)
                             || (cmd_op == dlp_pkg::CMD_ALLOW_DEEP);
  wire logic [1:0] cmd_lvl   = (cmd_op == dlp_pkg::CMD_ALLOW_DEEP) ? dlp_pkg::LVL_DEEP
                                                                   : dlp_pkg::LVL_SHALLOW;
  // [R5] backlight pin check
  wire logic       bad_bl    = (cmd_op == dlp_pkg::CMD_ALLOW_DEEP) && backlight_util_pin;
  // [R16] no image check
  wire logic       bad_map   = (img_offset == dlp_pkg::MAP_NO_IMAGE)
  // [R17] map entry limit
                             || (map_entry_count > dlp_pkg::MAP_MAX_ENTRY);
  // [R18] outer header check
  wire logic       bad_outer = (module_kind_field != dlp_pkg::MODULE_KIND)
                             || (outer_hdr_ver != dlp_pkg::OUTER_HDR_VER);
  // [R19] image header check
  wire logic       bad_img   = (img_marker != dlp_pkg::IMG_MARKER)
                             || (init_write_count > dlp_pkg::INIT_MAX_PAIRS);
  wire logic       bad_op    = (cmd_op > dlp_pkg::CMD_DISALLOW_OFF);
  wire logic       refuse    = bad_op || (is_allow && (bad_bl || bad_map || bad_outer
                                                       || bad_img || off_r));
  wire logic       take      = cmd_valid && rdy_r && (state_r == dlp_pkg::ST_IDLE);
  // [R20] header write range
  wire logic       pair_ok   = (pair[63:32] >= dlp_pkg::INIT_ADDR_LO)
                             && (pair[63:32] <= dlp_pkg::INIT_ADDR_HI);
  wire logic [31:0] prog_adr = dlp_pkg::PROG_STORE_OFS + {14'h0, cnt_r, 2'h0};

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_nxt  = state_r;
    ret_nxt    = ret_r;
    level_nxt  = level_r;
    target_nxt = target_r;
    off_nxt    = off_r;
    err_nxt    = err_r;
    req_nxt    = req_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    cnt_nxt    = cnt_r;
    idx_nxt    = idx_r;
    phy_nxt    = phy_r && !phy_reinit_done;
    case (state_r)
      dlp_pkg::ST_IDLE:
      begin
        if (take && refuse)
        begin
          err_nxt = 1'b1;
        end
        else if (take)
        begin
          err_nxt    = 1'b0;
          target_nxt = cmd_lvl;
          cnt_nxt    = 16'h0;
          idx_nxt    = 4'h0;
          if (cmd_op == dlp_pkg::CMD_DISALLOW_OFF)
          begin
            // [R23] clear off allow
            off_nxt   = 1'b0;
            ret_nxt   = dlp_pkg::ST_FIN;
            state_nxt = dlp_pkg::ST_WAIT;
          end
          else if (is_allow && (level_r == dlp_pkg::LVL_DISABLE))
          begin
            state_nxt = dlp_pkg::ST_PAY;
          end
          else
          begin
            // [R9][R14] disallow on request
            // [R13] pass through disable
            level_nxt = dlp_pkg::LVL_DISABLE;
            state_nxt = dlp_pkg::ST_WAIT;
            ret_nxt   = is_allow ? dlp_pkg::ST_PAY
                      : (cmd_op == dlp_pkg::CMD_ALLOW_OFF) ? dlp_pkg::ST_OFFW
                      : dlp_pkg::ST_FIN;
          end
          if (state_nxt == dlp_pkg::ST_WAIT)
          begin
            req_nxt   = 1'b1;
            addr_nxt  = dlp_pkg::DYN_EN_OFS;
            wdata_nxt = {28'h0, off_nxt, 1'b0, level_nxt};
          end
          // [R8] PHY reinit after deep
          if ((level_r == dlp_pkg::LVL_DEEP) && (level_nxt == dlp_pkg::LVL_DISABLE))
          begin
            phy_nxt = 1'b1;
          end
        end
      end
      dlp_pkg::ST_PAY:
      begin
        if (cnt_r == program_size_field)
        begin
          state_nxt = dlp_pkg::ST_INI_RD;
        end
        // [R10] copy payload words
        else if (pl_valid && plr_r)
        begin
          req_nxt   = 1'b1;
          addr_nxt  = prog_adr;
          wdata_nxt = pl_data;
          cnt_nxt   = cnt_r + 16'h1;
          ret_nxt   = dlp_pkg::ST_PAY;
          state_nxt = dlp_pkg::ST_WAIT;
        end
      end
      dlp_pkg::ST_INI_RD:
      begin
        if (idx_r == init_write_count)
        begin
          // [R11] aux control bit
          req_nxt   = 1'b1;
          addr_nxt  = dlp_pkg::AUX_CTL_OFS;
          wdata_nxt = dlp_pkg::AUX_CTL_VAL;
          ret_nxt   = dlp_pkg::ST_ENW;
          state_nxt = dlp_pkg::ST_WAIT;
        end
        else
        begin
          state_nxt = dlp_pkg::ST_INI_CHK;
        end
      end
      dlp_pkg::ST_INI_CHK:
      begin
        idx_nxt = idx_r + 4'h1;
        // [R20] ordered header writes
        if (pair_ok)
        begin
          req_nxt   = 1'b1;
          addr_nxt  = pair[63:32];
          wdata_nxt = pair[31:0];
          ret_nxt   = dlp_pkg::ST_INI_RD;
          state_nxt = dlp_pkg::ST_WAIT;
        end
        else
        begin
          err_nxt   = 1'b1;
          state_nxt = dlp_pkg::ST_INI_RD;
        end
      end
      dlp_pkg::ST_ENW:
      begin
        // [R12] set enable field
        level_nxt = target_r;
        req_nxt   = 1'b1;
        addr_nxt  = dlp_pkg::DYN_EN_OFS;
        wdata_nxt = {28'h0, off_nxt, 1'b0, level_nxt};
        ret_nxt   = dlp_pkg::ST_FIN;
        state_nxt = dlp_pkg::ST_WAIT;
      end
      dlp_pkg::ST_OFFW:
      begin
        // [R21] off allow after disable
        off_nxt   = 1'b1;
        req_nxt   = 1'b1;
        addr_nxt  = dlp_pkg::DYN_EN_OFS;
        wdata_nxt = {28'h0, off_nxt, 1'b0, level_nxt};
        ret_nxt   = dlp_pkg::ST_FIN;
        state_nxt = dlp_pkg::ST_WAIT;
      end
      dlp_pkg::ST_WAIT:
      begin
        if (ack_s_r)
        begin
          req_nxt   = 1'b0;
          state_nxt = dlp_pkg::ST_REL;
        end
      end
      dlp_pkg::ST_REL:
      begin
        if (!ack_s_r)
        begin
          state_nxt = ret_r;
        end
      end
      dlp_pkg::ST_FIN:
      begin
        state_nxt = dlp_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt = dlp_pkg::ST_IDLE;
      end
    endcase
    rdy_nxt = (state_nxt == dlp_pkg::ST_IDLE);
    plr_nxt = (state_nxt == dlp_pkg::ST_PAY) && (cnt_nxt != program_size_field);
  end

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end
    else
    begin
      ack_m_r <= dev_ack;
      ack_s_r <= ack_m_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= dlp_pkg::ST_IDLE;
      ret_r    <= dlp_pkg::ST_IDLE;
      level_r  <= dlp_pkg::LVL_DISABLE;
      target_r <= dlp_pkg::LVL_DISABLE;
      off_r    <= 1'b0;
      err_r    <= 1'b0;
      rdy_r    <= 1'b0;
      plr_r    <= 1'b0;
      phy_r    <= 1'b0;
      req_r    <= 1'b0;
      addr_r   <= dlp_pkg::RST_WDATA;
      wdata_r  <= dlp_pkg::RST_WDATA;
      cnt_r    <= 16'h0;
      idx_r    <= 4'h0;
    end
    else
    begin
      state_r  <= state_nxt;
      ret_r    <= ret_nxt;
      level_r  <= level_nxt;
      target_r <= target_nxt;
      off_r    <= off_nxt;
      err_r    <= err_nxt;
      rdy_r    <= rdy_nxt;
      plr_r    <= plr_nxt;
      phy_r    <= phy_nxt;
      req_r    <= req_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      cnt_r    <= cnt_nxt;
      idx_r    <= idx_nxt;
    end
  end

  assign cmd_ready      = rdy_r;
  assign cmd_err        = err_r;
  assign lvl_state      = level_r;
  assign off_allowed    = off_r;
  assign pl_ready       = plr_r;
  assign phy_reinit_req = phy_r;
  assign dev_req        = req_r;
  assign dev_addr       = addr_r;
  assign dev_wdata      = wdata_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_deep_bl;
    @(posedge ref_clk) disable iff (!rst_n)
    take && (cmd_op == dlp_pkg::CMD_ALLOW_DEEP) && backlight_util_pin
      |=> err_r && (state_r == dlp_pkg::ST_IDLE) && (level_r != dlp_pkg::LVL_DEEP);
  endproperty
  a_deep_bl: assert property (p_deep_bl) else $error("deep allowed with backlight pin"); // R5

  property p_no_img;
    @(posedge ref_clk) disable iff (!rst_n)
    take && is_allow && (img_offset == dlp_pkg::MAP_NO_IMAGE) |=> err_r && !req_r;
  endproperty
  a_no_img: assert property (p_no_img) else $error("missing image not refused"); // R16

  property p_switch;
    @(posedge ref_clk) disable iff (!rst_n)
    ($past(level_r) != dlp_pkg::LVL_DISABLE) && (level_r != dlp_pkg::LVL_DISABLE)
      |-> (level_r == $past(level_r));
  endproperty
  a_switch: assert property (p_switch) else $error("direct level switch"); // R13

  property p_en_after_aux;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_r == dlp_pkg::ST_ENW) |-> (addr_r == dlp_pkg::AUX_CTL_OFS)
      && (wdata_r == dlp_pkg::AUX_CTL_VAL) && !dev_req;
  endproperty
  a_en_after_aux: assert property (p_en_after_aux) else $error("enable before aux bit"); // R11

  property p_init_range;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_r == dlp_pkg::ST_INI_CHK) && req_nxt |=> (dev_addr >= dlp_pkg::INIT_ADDR_LO)
      && (dev_addr <= dlp_pkg::INIT_ADDR_HI) && dev_req;
  endproperty
  a_init_range: assert property (p_init_range) else $error("header write out of range"); // R20

  property p_off_word;
    @(posedge ref_clk) disable iff (!rst_n)
    dev_req && (dev_addr == dlp_pkg::DYN_EN_OFS) && dev_wdata[dlp_pkg::OFF_ALLOW_BIT]
      |-> (dev_wdata[1:0] == dlp_pkg::LVL_DISABLE);
  endproperty
  a_off_word: assert property (p_off_word) else $error("off allow with level set"); // R21

  property p_req_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    dev_req && !ack_s_r |=> dev_req && $stable(dev_addr) && $stable(dev_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early"); // R10

  property p_init_cnt;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_r == dlp_pkg::ST_INI_CHK) |-> (idx_r < dlp_pkg::INIT_MAX_PAIRS);
  endproperty
  a_init_cnt: assert property (p_init_cnt) else $error("too many header writes"); // R19

  property p_phy;
    @(posedge ref_clk) disable iff (!rst_n)
    take && !refuse && (level_r == dlp_pkg::LVL_DEEP) && !phy_reinit_done
      && (cmd_op != dlp_pkg::CMD_DISALLOW_OFF) |=> phy_reinit_req;
  endproperty
  a_phy: assert property (p_phy) else $error("phy reinit not requested"); // R8
endmodule : dlp_host_ctrl

// file: verification/dlp_dev_model.sv
module dlp_dev_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        dev_req,
  input  wire logic [31:0] dev_addr,
  input  wire logic [31:0] dev_wdata,
  output logic             dev_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Device registers and write log
  // ****************************************
  logic [31:0] log_a [0:63];
  logic [31:0] log_d [0:63];
  int          wr_cnt;
  int          dly;
  int          prog_words;
  logic [31:0] aux_ctl_r;
  logic [31:0] en_r;

  // ****************************************
  // Four-phase write answer
  // ****************************************
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_words <= 0;
      dev_ack    <= 1'b0;
      dly        <= 0;
      wr_cnt     <= 0;
      aux_ctl_r  <= 32'h0;
      en_r       <= 32'h0;
    end
    else if (dev_req && !dev_ack)
    begin
      if (dly < (slow ? 3 : 0))
        dly <= dly + 1;
      else
      begin
        dev_ack               <= 1'b1;
        dly                   <= 0;
        wr_cnt                <= wr_cnt + 1;
        log_a[wr_cnt[5:0]]    <= dev_addr;
        log_d[wr_cnt[5:0]]    <= dev_wdata;
        if (dev_addr == dlp_pkg::AUX_CTL_OFS)
          aux_ctl_r <= dev_wdata;
        if (dev_addr == dlp_pkg::DYN_EN_OFS)
          en_r <= dev_wdata;
        if (dev_addr[19:16] == 4'h9)
          prog_words <= prog_words + 1;
      end
    end
    else if (!dev_req && dev_ack)
      dev_ack <= 1'b0;
  end
endmodule : dlp_dev_model

// file: verification/dlp_host_ctrl_tb.sv
module dlp_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic        backlight_util_pin = 1'b0;
  logic [31:0] img_offset = 32'h0;
  logic [31:0] module_kind_field = dlp_pkg::MODULE_KIND;
  logic [31:0] outer_hdr_ver = dlp_pkg::OUTER_HDR_VER;
  logic [31:0] img_marker = dlp_pkg::IMG_MARKER;
  logic [4:0]  map_entry_count = dlp_pkg::MAP_MAX_ENTRY;
  logic [15:0] program_size_field = 16'h2;
  logic [3:0]  init_write_count = 4'h2;
  logic        tbl_we = 1'b0;
  logic [2:0]  tbl_idx = 3'h0;
  logic [31:0] tbl_addr = 32'h0;
  logic [31:0] tbl_data = 32'h0;
  logic        pl_valid = 1'b1;
  logic [31:0] pl_idx = 32'h0;
  logic        phy_reinit_done = 1'b0;
  logic        slow = 1'b0;
  logic [1:0]  cur_lvl = 2'h0;
  logic [63:0] exp_q [$];
  int          fail_count = 0;
  int          checks = 0;
  wire         cmd_ready;
  wire         cmd_err;
  wire  [1:0]  lvl_state;
  wire         off_allowed;
  wire         pl_ready;
  wire         phy_reinit_req;
  wire         dev_req;
  wire         dev_ack;
  wire  [31:0] dev_addr;
  wire  [31:0] dev_wdata;
  wire  [31:0] pl_data = 32'hc0de_0000 + pl_idx;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (pl_valid && pl_ready)
      pl_idx <= pl_idx + 32'h1;

  dlp_host_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .backlight_util_pin(backlight_util_pin), .img_offset(img_offset),
    .module_kind_field(module_kind_field), .outer_hdr_ver(outer_hdr_ver),
    .img_marker(img_marker), .map_entry_count(map_entry_count),
    .program_size_field(program_size_field), .init_write_count(init_write_count),
    .tbl_we(tbl_we), .tbl_idx(tbl_idx), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
    .pl_valid(pl_valid), .pl_data(pl_data), .phy_reinit_done(phy_reinit_done),
    .dev_ack(dev_ack), .cmd_ready(cmd_ready), .cmd_err(cmd_err), .lvl_state(lvl_state),
    .off_allowed(off_allowed), .pl_ready(pl_ready), .phy_reinit_req(phy_reinit_req),
    .dev_req(dev_req), .dev_addr(dev_addr), .dev_wdata(dev_wdata));

  dlp_dev_model u_dev (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .dev_req(dev_req),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic push(input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back({a, d});
  endtask : push

  task automatic exp_allow(input logic [1:0] lvl);
    int i;
    if (cur_lvl != 2'h0)
      push(dlp_pkg::DYN_EN_OFS, 32'h0);
    for (i = 0; i < program_size_field; i++)
      push(dlp_pkg::PROG_STORE_OFS + 4 * i, 32'hc0de_0000 + pl_idx + i);
    for (i = 0; i < init_write_count; i++)
      if (i != 3)
        push(dlp_pkg::INIT_ADDR_LO + 4 * i, 32'h5a00 + i);
    push(dlp_pkg::AUX_CTL_OFS, dlp_pkg::AUX_CTL_VAL);
    push(dlp_pkg::DYN_EN_OFS, {30'h0, lvl});
    cur_lvl = lvl;
  endtask : exp_allow

  task automatic run_cmd(input logic [2:0] op, input logic exp_err);
    int n0;
    int t;
    int i;
    n0 = u_dev.wr_cnt;
    cmd_op = op;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    cyc(2);
    for (t = 0; t < 3000 && cmd_ready !== 1'b1; t++)
      cyc(1);
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    chk_word("write count", exp_q.size(), u_dev.wr_cnt - n0);
    for (i = 0; i < exp_q.size() && i < u_dev.wr_cnt - n0; i++)
    begin
      chk_word("dev_addr", exp_q[i][63:32], u_dev.log_a[n0 + i]);
      chk_word("dev_wdata", exp_q[i][31:0], u_dev.log_d[n0 + i]);
    end
    chk_bit("cmd_err", exp_err, cmd_err);
    exp_q.delete();
  endtask : run_cmd

  task automatic set_hdr(input int k);
    backlight_util_pin = (k == 0);
    img_offset = (k == 1) ? dlp_pkg::MAP_NO_IMAGE : 32'h0;
    module_kind_field = (k == 2) ? 32'h8 : dlp_pkg::MODULE_KIND;
    outer_hdr_ver = (k == 3) ? 32'h1 : dlp_pkg::OUTER_HDR_VER;
    img_marker = (k == 4) ? 32'h0 : dlp_pkg::IMG_MARKER;
    map_entry_count = (k == 5) ? 5'h15 : dlp_pkg::MAP_MAX_ENTRY;
    init_write_count = (k == 6) ? 4'h9 : 4'h2;
  endtask : set_hdr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    cyc(2);
    chk_bit("cmd_ready in reset", 1'b0, cmd_ready);
    rst_n = 1'b1;
    cyc(2);
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    chk_word("lvl_state", 32'h0, {30'h0, lvl_state});
    chk_bit("off_allowed", 1'b0, off_allowed);
  endtask : t_reset

  task automatic t_load();
    int i;
    tbl_we = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      tbl_idx = i[2:0];
      tbl_addr = (i == 3) ? dlp_pkg::PROG_STORE_OFS : dlp_pkg::INIT_ADDR_LO + 4 * i;
      tbl_data = 32'h5a00 + i;
      cyc(1);
    end
    tbl_we = 1'b0;
  endtask : t_load

  task automatic t_shallow();
    exp_allow(dlp_pkg::LVL_SHALLOW);
    run_cmd(dlp_pkg::CMD_ALLOW_SHALLOW, 1'b0);
    chk_word("lvl_state", 32'h1, {30'h0, lvl_state});
    chk_word("aux control", dlp_pkg::AUX_CTL_VAL, u_dev.aux_ctl_r);
    chk_word("payload words", 32'h2, pl_idx);
    chk_bit("pl_ready", 1'b0, pl_ready);
  endtask : t_shallow

  task automatic t_deep();
    slow = 1'b1;
    program_size_field = 16'h0;
    init_write_count = 4'h8;
    exp_allow(dlp_pkg::LVL_DEEP);
    run_cmd(dlp_pkg::CMD_ALLOW_DEEP, 1'b1);
    chk_word("lvl_state", 32'h2, {30'h0, lvl_state});
    chk_word("payload words", 32'h2, pl_idx);
    slow = 1'b0;
    program_size_field = 16'h2;
    init_write_count = 4'h2;
  endtask : t_deep

  task automatic t_disallow();
    push(dlp_pkg::DYN_EN_OFS, 32'h0);
    cur_lvl = 2'h0;
    run_cmd(dlp_pkg::CMD_DISALLOW, 1'b0);
    chk_word("lvl_state", 32'h0, {30'h0, lvl_state});
    chk_bit("phy_reinit_req", 1'b1, phy_reinit_req);
    phy_reinit_done = 1'b1;
    cyc(1);
    phy_reinit_done = 1'b0;
    cyc(1);
    chk_bit("phy_reinit_req", 1'b0, phy_reinit_req);
  endtask : t_disallow

  task automatic t_refuse();
    int k;
    for (k = 0; k < 10; k++)
    begin
      set_hdr(k);
      run_cmd((k == 0) ? dlp_pkg::CMD_ALLOW_DEEP : (k >= 7) ? 3'(k - 2) : 3'h0, 1'b1);
    end
    set_hdr(-1);
    chk_word("lvl_state", 32'h0, {30'h0, lvl_state});
  endtask : t_refuse

  task automatic t_off();
    push(dlp_pkg::DYN_EN_OFS, 32'h0);
    push(dlp_pkg::DYN_EN_OFS, 32'h8);
    run_cmd(dlp_pkg::CMD_ALLOW_OFF, 1'b0);
    chk_bit("off_allowed", 1'b1, off_allowed);
    run_cmd(dlp_pkg::CMD_ALLOW_SHALLOW, 1'b1);
    push(dlp_pkg::DYN_EN_OFS, 32'h0);
    run_cmd(dlp_pkg::CMD_DISALLOW_OFF, 1'b0);
    chk_bit("off_allowed", 1'b0, off_allowed);
  endtask : t_off

  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    t_reset();
    t_load();
    t_shallow();
    t_deep();
    t_disallow();
    t_refuse();
    t_off();
    stop_test();
  end
endmodule : dlp_host_ctrl_tb
